// ===== hdl/port4_pkg.sv
/*
  Constants, register offsets and carrier structs for the port 4 I/O and
  pin multiplexing block. Assumes one synchronous clock domain and control
  bits that neighbouring peripherals present as steady levels.
*/
// Functional notes
// - Expansion enabled in modes 1 to 3: port 3 pull-ups always off.
// - Modes 2/3, no expansion: pull-up on only if input and enable bit set.
// - Port 4 is 8 bits wide; its pin functions ignore operating mode.
// - Direction bit 1 means output, 0 input; write-only, resets to zero.
// - Port read gives latch for output bits, pin level for input bits.
// - Output latch is 8-bit read/write, resets to zero, drives output pins.
// - In software standby PWM is reset; pins follow timer, hsync, host IRQ, port bits.
// - Pin 7 drives PWM output 1 when its enable B is set, else GPIO.
// - Pin 6 drives PWM output 0 when its enable A is set, else GPIO.
// - Pin 5 output is latch, or host IRQ 12 when the IRQ pin enable is set.
// - Pin 5 feeds timer 1 counter reset when both clear selects are 1.
// - Pin 4 drives hsync when enabled, else timer 1 compare if selected.
// - Otherwise pin 4 is GPIO, or host IRQ 1 output when IRQ enable is set.
// - Pin 3 output is latch, or host IRQ 11 when the IRQ pin enable is set.
// - Pin 3 feeds timer 1 external clock when clock select picks external.
package port4_pkg;

  localparam int unsigned  ADDR_W          = 8;
  localparam int unsigned  DATA_W          = 8;

  // Register offsets
  localparam logic [7:0]   P4_DIR_OFS      = 8'h00;
  localparam logic [7:0]   P4_LATCH_OFS    = 8'h01;
  localparam logic [7:0]   P3_DIR_OFS      = 8'h02;
  localparam logic [7:0]   P3_PULLUP_OFS   = 8'h03;
  localparam logic [7:0]   PIN_FUNC_OFS    = 8'h04;

  // Values after reset
  localparam logic [7:0]   P4_DIR_RST      = 8'h00;
  localparam logic [7:0]   P4_LATCH_RST    = 8'h00;
  localparam logic [7:0]   P3_DIR_RST      = 8'h00;
  localparam logic [7:0]   P3_PULLUP_RST   = 8'h00;

  // Operating mode and clock select codes
  localparam logic [1:0]   MODE_1          = 2'h1;
  localparam logic [2:0]   CKS_EXT_FIRST   = 3'h5;

  // Control levels from neighbouring units
  typedef struct packed {
    logic       pwm_output_enable_a;
    logic       pwm_output_enable_b;
    logic       host_irq_pin_enable;
    logic       hsync_output_enable;
    logic [3:0] timer1_output_select;
    logic       counter_clear_sel_hi;
    logic       counter_clear_sel_lo;
    logic [2:0] timer_clock_select;
    logic       external_expansion_enable;
    logic [1:0] op_mode;
    logic       sw_standby;
    logic       hw_standby;
  } periph_ctrl_s;

  // Peripheral signals that may take over a pin
  typedef struct packed {
    logic pwm_out_0;
    logic pwm_out_1;
    logic host_irq_out_1;
    logic host_irq_out_11;
    logic host_irq_out_12;
    logic timer1_compare_out;
    logic hsync_out;
  } periph_sig_s;

  // Pin levels handed to timer 1 and the sync logic
  typedef struct packed {
    logic timer1_reset_in;
    logic timer1_clock_in;
    logic composite_sync_in;
    logic hsync_in;
  } timer_feed_s;

endpackage

// ===== hdl/upper_pin_mux.sv
/*
  Combinational function select for port 4 pins 7 to 3. Assumes the
  control struct already has standby gating applied by the caller.
*/
`timescale 1ns/100ps
module upper_pin_mux
  import port4_pkg::*;
(
  // Port settings
  input  wire logic [7:3] dir,
  input  wire logic [7:3] latch,
  // Selection sources
  input  wire periph_ctrl_s ctrl,
  input  wire periph_sig_s  sig,
  // Pin drive
  output logic      [7:3] oe,
  output logic      [7:3] dout,
  output logic      [7:3] taken
);

  always_comb
  begin
    oe    = dir;
    dout  = latch;
    taken = 5'h00;
    if (ctrl.pwm_output_enable_a)
    begin
      oe[6]    = 1'b1;
      dout[6]  = sig.pwm_out_0;
      taken[6] = 1'b1;
    end
    if (ctrl.pwm_output_enable_b)
    begin
      oe[7]    = 1'b1;
      dout[7]  = sig.pwm_out_1;
      taken[7] = 1'b1;
    end
    if (dir[5] && ctrl.host_irq_pin_enable)
    begin
      dout[5]  = sig.host_irq_out_12;
      taken[5] = 1'b1;
    end
    // pin 4 hsync first, then compare
    if (ctrl.hsync_output_enable)
    begin
      oe[4]    = 1'b1;
      dout[4]  = sig.hsync_out;
      taken[4] = 1'b1;
    end
    else if (ctrl.timer1_output_select != 4'h0)
    begin
      oe[4]    = 1'b1;
      dout[4]  = sig.timer1_compare_out;
      taken[4] = 1'b1;
    end
    else if (dir[4] && ctrl.host_irq_pin_enable)
    begin
      dout[4]  = sig.host_irq_out_1;
      taken[4] = 1'b1;
    end
    if (dir[3] && ctrl.host_irq_pin_enable)
    begin
      dout[3]  = sig.host_irq_out_11;
      taken[3] = 1'b1;
    end
  end

endmodule

// ===== hdl/pullup_gate.sv
/*
  Port 3 input pull-up gating. Assumes mode and expansion levels are
  steady system straps and standby levels come from the power control.
*/
`timescale 1ns/100ps
module pullup_gate
  import port4_pkg::*;
(
  // Port 3 settings
  input  wire logic [7:0] dir,
  input  wire logic [7:0] enable,
  // System state
  input  wire periph_ctrl_s ctrl,
  // Pull-up request
  output logic      [7:0] pu_req
);

  always_comb
  begin
    // expansion, mode 1 or hardware standby keeps all off
    if (ctrl.external_expansion_enable || ctrl.op_mode == MODE_1 || ctrl.hw_standby)
    begin
      pu_req = 8'h00;
    end
    // input pin with enable bit set
    else
    begin
      pu_req = ~dir & enable;
    end
  end

endmodule

// ===== hdl/port4_io_pin_mux.sv
/*
  Port 4 general I/O with function multiplexing for pins 7 to 3, and the
  port 3 pull-up control. Assumes a one-cycle strobe register port, pins
  already synchronous to clk, and peripheral controls as steady levels.
*/
`timescale 1ns/100ps
module port4_io_pin_mux
  import port4_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  // Port 4 pins
  input  wire logic [7:0]        p4_in,
  output logic      [7:0]        p4_out,
  output logic      [7:0]        p4_oe,
  // Port 3 pull-ups
  output logic      [7:0]        p3_pullup_on,
  // Peripheral side
  input  wire periph_ctrl_s      ctrl,
  input  wire periph_sig_s       sig,
  output timer_feed_s            feed
);

  logic         [7:0] p4_dir_reg;
  logic         [7:0] p4_latch_reg;
  logic         [7:0] p3_dir_reg;
  logic         [7:0] p3_pullup_reg;
  logic         [7:0] p4_out_next;
  logic         [7:0] p4_oe_next;
  logic         [7:0] p4_taken_next;
  logic         [7:0] p4_taken_reg;
  logic         [7:0] p4_read_view;
  logic         [7:0] pullup_next;
  logic         [7:0] rdata_next;
  logic         [7:3] mux_oe;
  logic         [7:3] mux_out;
  logic         [7:3] mux_taken;
  logic               wr_p4_dir;
  logic               wr_p4_latch;
  logic               wr_p3_dir;
  logic               wr_p3_pullup;
  logic               ext_clock_sel;
  logic               reset_in_sel;
  periph_ctrl_s       ctrl_eff;
  timer_feed_s        feed_next;

  // Write decode
  assign wr_p4_dir    = wr && (addr == P4_DIR_OFS);
  assign wr_p4_latch  = wr && (addr == P4_LATCH_OFS);
  assign wr_p3_dir    = wr && (addr == P3_DIR_OFS);
  assign wr_p3_pullup = wr && (addr == P3_PULLUP_OFS);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      p4_dir_reg <= P4_DIR_RST;
    end
    else if (wr_p4_dir)
    begin
      p4_dir_reg <= wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      p4_latch_reg <= P4_LATCH_RST;
    end
    else if (wr_p4_latch)
    begin
      p4_latch_reg <= wdata;
    end
  end

  // Port 3 direction, write-only like port 4
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      p3_dir_reg <= P3_DIR_RST;
    end
    else if (wr_p3_dir)
    begin
      p3_dir_reg <= wdata;
    end
  end

  // Port 3 pull-up enables
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      p3_pullup_reg <= P3_PULLUP_RST;
    end
    else if (wr_p3_pullup)
    begin
      p3_pullup_reg <= wdata;
    end
  end

  // PWM is held reset in software standby
  always_comb
  begin
    ctrl_eff = ctrl;
    if (ctrl.sw_standby)
    begin
      ctrl_eff.pwm_output_enable_a = 1'b0;
      ctrl_eff.pwm_output_enable_b = 1'b0;
    end
  end

  // selection is pure decode of current bits
  upper_pin_mux u_mux (
    .dir   (p4_dir_reg[7:3]),
    .latch (p4_latch_reg[7:3]),
    .ctrl  (ctrl_eff),
    .sig   (sig),
    .oe    (mux_oe),
    .dout  (mux_out),
    .taken (mux_taken)
  );

  // pins 2 to 0 stay plain GPIO here
  assign p4_oe_next    = {mux_oe, p4_dir_reg[2:0]};
  assign p4_out_next   = {mux_out, p4_latch_reg[2:0]};
  assign p4_taken_next = {mux_taken, 3'h0};

  // Registered pin drive avoids glitches on control changes
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      p4_oe        <= 8'h00;
      p4_out       <= 8'h00;
      p4_taken_reg <= 8'h00;
    end
    else
    begin
      p4_oe        <= p4_oe_next;
      p4_out       <= p4_out_next;
      p4_taken_reg <= p4_taken_next;
    end
  end

  pullup_gate u_pullup (
    .dir    (p3_dir_reg),
    .enable (p3_pullup_reg),
    .ctrl   (ctrl),
    .pu_req (pullup_next)
  );

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      p3_pullup_on <= 8'h00;
    end
    else
    begin
      p3_pullup_on <= pullup_next;
    end
  end

  // counter reset needs both clear selects
  assign reset_in_sel  = ctrl.counter_clear_sel_hi && ctrl.counter_clear_sel_lo;
  assign ext_clock_sel = ctrl.timer_clock_select >= CKS_EXT_FIRST;

  always_comb
  begin
    feed_next.timer1_reset_in   = reset_in_sel && p4_in[5];
    feed_next.timer1_clock_in   = ext_clock_sel && p4_in[3];
    feed_next.composite_sync_in = p4_in[5];
    feed_next.hsync_in          = p4_in[3];
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      feed <= '0;
    end
    else
    begin
      feed <= feed_next;
    end
  end

  // output bits read back the latch, not the pin
  assign p4_read_view = (p4_dir_reg & p4_latch_reg) | (~p4_dir_reg & p4_in);

  always_comb
  begin
    rdata_next = 8'h00;
    if (rd)
    begin
      case (addr)
        P4_LATCH_OFS:  rdata_next = p4_read_view;
        P3_PULLUP_OFS: rdata_next = p3_pullup_reg;
        PIN_FUNC_OFS:  rdata_next = p4_taken_reg;
        default:       rdata_next = 8'h00;
      endcase
    end
  end

  // Data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata <= 8'h00;
    end
    else
    begin
      rdata <= rdata_next;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  expansion_pullup_a:
    assert property ($past(ctrl.external_expansion_enable) |-> p3_pullup_on == 8'h00)
    else $error("Pull-up on with expansion enabled");

  pullup_follow_a:
    assert property (wr_p3_pullup && !ctrl.external_expansion_enable
                     && ctrl.op_mode != MODE_1 && !ctrl.hw_standby
                     && $stable(ctrl) ##1 $stable(ctrl)
                     |=> p3_pullup_on == (~$past(p3_dir_reg) & $past(wdata, 2)))
    else $error("Pull-up does not follow settings");

  dir_write_a:
    assert property (wr_p4_dir ##1 !wr_p4_dir |=> p4_oe[2:0] == $past(wdata[2:0], 2))
    else $error("Direction write lost");

  // read path mixes latch and pins
  port_read_a:
    assert property (rd && addr == P4_LATCH_OFS
                     |=> rdata == (($past(p4_dir_reg) & $past(p4_latch_reg))
                                   | (~$past(p4_dir_reg) & $past(p4_in))))
    else $error("Port read value wrong");

  // latch write then read back as output bit
  latch_write_a:
    assert property (wr_p4_latch && p4_dir_reg == 8'hff ##1 rd && addr == P4_LATCH_OFS
                     && !$changed(p4_dir_reg) |=> rdata == $past(wdata, 2))
    else $error("Latch readback wrong");

  // standby returns pin 6 to GPIO
  standby_pwm_a:
    assert property (ctrl.sw_standby |=> p4_oe[6] == $past(p4_dir_reg[6]))
    else $error("PWM active in standby");

  pin7_pwm_a:
    assert property (ctrl.pwm_output_enable_b && !ctrl.sw_standby
                     |=> p4_oe[7] && p4_out[7] == $past(sig.pwm_out_1))
    else $error("Pin 7 PWM not driven");

  pin5_irq_a:
    assert property (p4_dir_reg[5] && ctrl.host_irq_pin_enable
                     |=> p4_oe[5] && p4_out[5] == $past(sig.host_irq_out_12))
    else $error("Pin 5 IRQ not driven");

  reset_tap_a:
    assert property (reset_in_sel |=> feed.timer1_reset_in == $past(p4_in[5]))
    else $error("Timer reset tap wrong");

  pin4_hsync_a:
    assert property (ctrl.hsync_output_enable
                     |=> p4_oe[4] && p4_out[4] == $past(sig.hsync_out))
    else $error("Pin 4 hsync not driven");

  clock_tap_a:
    assert property (!ext_clock_sel |=> !feed.timer1_clock_in)
    else $error("Timer clock leaks");

endmodule

// ===== tb/board_model.sv
/*
  Board-side model of the port 4 pins.
  Assumes the bench gives a fresh level for every released pin each cycle.
*/
`timescale 1ns/100ps
module board_model
(
  // Design drive
  input  wire logic [7:0] p4_out,
  input  wire logic [7:0] p4_oe,
  // Level on released pins
  input  wire logic [7:0] ext,
  // Level seen by the design
  output logic      [7:0] p4_in
);
  // No pull-ups here, so a released pin never keeps its last driven level
  assign p4_in = (p4_oe & p4_out) | (~p4_oe & ext);
endmodule

// ===== tb/tb_port4_io_pin_mux.sv
/*
  Self-checking bench for the port 4 I/O and pin mux block.
  Assumes the board model closes the pin loop, one clock domain.
*/
`timescale 1ns/100ps
module tb_port4_io_pin_mux
  import port4_pkg::*;
;
  typedef struct packed
  {
    logic [7:0] oe;
    logic [7:0] out;
    logic [7:0] pu;
    logic [7:0] rd;
    logic [3:0] fd;
  } exp_s;
  localparam int LIMIT = 5000;
  logic         clk;
  logic         nrst;
  logic         wr;
  logic         rd;
  logic [7:0]   addr;
  logic [7:0]   wdata;
  logic [7:0]   rdata;
  logic [7:0]   p4_in;
  logic [7:0]   p4_out;
  logic [7:0]   p4_oe;
  logic [7:0]   p3_pullup_on;
  logic [7:0]   ext;
  periph_ctrl_s ctrl;
  periph_sig_s  sig;
  timer_feed_s  feed;
  logic [7:0]   dir4;
  logic [7:0]   lat4;
  logic [7:0]   dir3;
  logic [7:0]   pu3;
  logic [7:0]   po;
  logic [7:0]   poe;
  logic         pw;
  logic [7:0]   pa;
  logic [7:0]   pd;
  logic [31:0]  seed;
  logic [31:0]  rv;
  logic [7:0]   av;
  logic [7:0]   ptk;
  exp_s         me;
  exp_s         q[$];
  int           err_count;
  int           n_checks;
  int           cycles;

  port4_io_pin_mux u_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .p4_in(p4_in), .p4_out(p4_out), .p4_oe(p4_oe),
    .p3_pullup_on(p3_pullup_on), .ctrl(ctrl), .sig(sig), .feed(feed));
  board_model u_board (.p4_out(p4_out), .p4_oe(p4_oe), .ext(ext), .p4_in(p4_in));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
    end
  endfunction

  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    begin
      n_checks++;
      if (got !== ex)
      begin
        err_count++;
        $display("FAIL %s expected %h got %h", nm, ex, got);
      end
    end
  endtask

  task automatic summarize();
    begin
      if (err_count == 0 && n_checks > 0)
      begin
        $display("ALL CHECKS OK");
      end
      else
      begin
        $display("CHECKS NOT OK");
      end
      $finish;
    end
  endtask

  // One bus cycle plus fresh random peripheral signals; notes the result
  task automatic step(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    exp_s         e;
    periph_ctrl_s c;
    periph_sig_s  s;
    logic [7:0]   x;
    logic [7:0]   pin;
    logic [7:0]   tk;
    begin
      @(posedge clk);
      if (pw)
      begin
        case (pa)
          P4_DIR_OFS:    dir4 = pd;
          P4_LATCH_OFS:  lat4 = pd;
          P3_DIR_OFS:    dir3 = pd;
          P3_PULLUP_OFS: pu3 = pd;
          default:       ;
        endcase
      end
      rv = rnd();
      // Controls mostly held so that settled paths are exercised too
      c = (rv[19:18] != 2'h0) ? ctrl : periph_ctrl_s'(rv[17:0]);
      // Mode 0 is not a legal strap
      if (c.op_mode == 2'h0)
      begin
        c.op_mode = 2'h2;
      end
      rv = rnd();
      s = periph_sig_s'(rv[6:0]);
      x = rv[15:8];
      pin = (poe & po) | (~poe & x);
      e.oe = dir4;
      e.out = lat4;
      if (c.host_irq_pin_enable)
      begin
        e.out[5] = s.host_irq_out_12;
        e.out[4] = s.host_irq_out_1;
        e.out[3] = s.host_irq_out_11;
      end
      if (c.hsync_output_enable || (c.timer1_output_select != 4'h0))
      begin
        e.oe[4] = 1'b1;
        e.out[4] = c.hsync_output_enable ? s.hsync_out : s.timer1_compare_out;
      end
      if (c.pwm_output_enable_b && !c.sw_standby)
      begin
        e.oe[7] = 1'b1;
        e.out[7] = s.pwm_out_1;
      end
      if (c.pwm_output_enable_a && !c.sw_standby)
      begin
        e.oe[6] = 1'b1;
        e.out[6] = s.pwm_out_0;
      end
      e.pu = (c.external_expansion_enable || c.hw_standby || (c.op_mode == MODE_1)) ?
        8'h00 : (~dir3 & pu3);
      e.fd = {c.counter_clear_sel_hi & c.counter_clear_sel_lo & pin[5],
        (c.timer_clock_select >= CKS_EXT_FIRST) & pin[3], pin[5], pin[3]};
      e.rd = 8'h00;
      if (r && a == P4_LATCH_OFS)
      begin
        e.rd = (dir4 & lat4) | (~dir4 & pin);
      end
      if (r && a == P3_PULLUP_OFS)
      begin
        e.rd = pu3;
      end
      // Function status lags the pin drive by one cycle
      tk = {c.pwm_output_enable_b & !c.sw_standby,
        c.pwm_output_enable_a & !c.sw_standby,
        dir4[5] & c.host_irq_pin_enable,
        c.hsync_output_enable | (c.timer1_output_select != 4'h0)
          | (dir4[4] & c.host_irq_pin_enable),
        dir4[3] & c.host_irq_pin_enable, 3'h0};
      if (r && a == PIN_FUNC_OFS)
      begin
        e.rd = ptk;
      end
      ptk = tk;
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= r;
      ctrl <= c;
      sig <= s;
      ext <= x;
      pw = w;
      pa = a;
      pd = d;
      q.push_back(e);
      po = e.out;
      poe = e.oe;
    end
  endtask

  always
  begin
    @(posedge clk);
    #1;
    if (nrst && q.size() > 1)
    begin
      me = q.pop_front();
      chk("p4_oe", me.oe, p4_oe);
      chk("p4_out", me.out & me.oe, p4_out & me.oe);
      chk("p3_pullup_on", me.pu, p3_pullup_on);
      chk("rdata", me.rd, rdata);
      chk("feed", {4'h0, me.fd}, {4'h0, feed});
    end
  end

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      err_count++;
      summarize();
    end
  end

  initial
  begin
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    ctrl = '0;
    sig = '0;
    ext = 8'h00;
    seed = 32'hdeb7_dd87;
    {dir4, lat4, dir3, pu3, po, poe, pa, pd, ptk} = '0;
    pw = 1'b0;
    err_count = 0;
    n_checks = 0;
    cycles = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk("reset p4_oe", 8'h00, p4_oe);
    chk("reset p3_pullup_on", 8'h00, p3_pullup_on);
    chk("reset rdata", 8'h00, rdata);
    step(1'b1, 1'b0, P4_DIR_OFS, 8'hff);
    step(1'b0, 1'b1, P4_LATCH_OFS, 8'h00);
    step(1'b1, 1'b0, P4_LATCH_OFS, 8'ha5);
    step(1'b0, 1'b1, P4_LATCH_OFS, 8'h00);
    step(1'b0, 1'b1, P4_DIR_OFS, 8'h00);
    step(1'b1, 1'b0, P4_DIR_OFS, 8'h0f);
    step(1'b1, 1'b0, P3_DIR_OFS, 8'h0f);
    step(1'b1, 1'b0, P3_PULLUP_OFS, 8'hff);
    step(1'b0, 1'b1, P4_LATCH_OFS, 8'h00);
    // Random traffic, mapped and unmapped addresses alike
    repeat (3000)
    begin
      rv = rnd();
      av = rv[8] ? {5'h00, rv[12:10]} : {1'b1, rv[22:16]};
      step(rv[1:0] == 2'h1, rv[1:0] == 2'h2, av, rv[31:24]);
    end
    step(1'b0, 1'b0, 8'h00, 8'h00);
    step(1'b0, 1'b0, 8'h00, 8'h00);
    summarize();
  end
endmodule
